// ==== dv/mcu_instruction_execution_timing_tb_top.sv ====
// self-checking bench for the instruction execution core
`timescale 1ns/1ps
module mcu_instruction_execution_timing_tb_top;
    import miet_pkg::*;
    typedef logic [15:0] miet_prog_t[$];
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [PC_W-1:0] prog_addr;
    logic [15:0] prog_data;
    logic wake_req = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic halted;
    int n_mismatch = 0;
    int checked = 0;
    int base = 0;
    miet_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .prog_addr(prog_addr),
        .prog_data(prog_data), .wake_req(wake_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halted(halted));
    miet_prog_mem mem (.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_data(prog_data));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        while (halted !== v) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > 3000) begin
                chk("halt wait", 16'h0001, 16'h0000);
                give_verdict();
            end
        end
    endtask : wait_lvl
    // negative count records the baseline
    task automatic run_prog(input miet_prog_t p, input int slow, input int ncyc,
            input logic [7:0] acc, input logic [1:0] fl, input logic [1:0] msk);
        int n;
        logic [7:0] d;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        for (int i = 0; i < 4096; i++) begin
            mem.rom[i] = 16'hF000;
        end
        foreach (p[i]) begin
            mem.rom[i] = p[i];
        end
        mem.rom[12'hF30] = 16'h12A5;
        mem.slow = slow;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_lvl(1'b1, n);
        if (ncyc < 0) begin
            base = n;
        end else begin
            chk("clocks to halt", 16'(base + 4 * ncyc), 16'(n));
        end
        reg_read(REG_ACC, d);
        chk("acc", {8'h00, acc}, {8'h00, d});
        reg_read(REG_STATUS, d);
        chk("flags", {14'h0, fl & msk}, {14'h0, d[1:0] & msk});
        $display("program run done");
    endtask : run_prog
    task automatic t_arith;
        miet_prog_t p;
        run_prog('{16'h8200}, 0, -1, 8'h00, 2'b00, 2'b00);
        run_prog('{16'h17FF, 16'h1001, 16'h8200}, 2, 2, 8'h00, 2'b11, 2'b11);
        run_prog('{16'h1700, 16'h1201, 16'h8200}, 0, 2, 8'hFF, 2'b10, 2'b11);
        run_prog('{16'h17F0, 16'h140F, 16'h8200}, 0, 2, 8'h00, 2'b01, 2'b01);
        run_prog('{16'h1700, 16'h1581, 16'h8200}, 0, 2, 8'h81, 2'b00, 2'b01);
        run_prog('{16'h17FF, 16'h0F10, 16'h2010, 16'h8200}, 2, 3, 8'h00, 2'b01, 2'b01);
        // carry in on add, borrow in on subtract, zero from exclusive or
        p = '{16'h17FF, 16'h1001, 16'h1100, 16'h1202, 16'h130F, 16'h16EF, 16'h8200};
        run_prog(p, 2, 6, 8'h00, 2'b01, 2'b11);
        $display("arith test done");
    endtask : t_arith
    task automatic t_mem;
        miet_prog_t p;
        p = '{16'h1780, 16'h0F10, 16'h3810, 16'h3710, 16'h2A10, 16'h2110, 16'h8200};
        run_prog(p, 0, 6, 8'h01, 2'b00, 2'b01);
        p = '{16'h1701, 16'h0F11, 16'h17FF, 16'h1001, 16'h2E11, 16'h2B11, 16'h0711, 16'h8200};
        run_prog(p, 2, 7, 8'h81, 2'b00, 2'b10);
        // right through carry, then plain left
        p = '{16'h17FF, 16'h1001, 16'h1703, 16'h0F12, 16'h2D12, 16'h2C12, 16'h0712, 16'h8200};
        run_prog(p, 0, 7, 8'h03, 2'b10, 2'b10);
        $display("mem test done");
    endtask : t_mem
    task automatic t_flow;
        miet_prog_t p;
        p = '{16'h1700, 16'h0F20, 16'h5020, 16'h1733, 16'h1001, 16'h5120, 16'h1001,
            16'h4F20, 16'h4020, 16'h1740, 16'h8200};
        run_prog(p, 2, 10, 8'h02, 2'b00, 2'b00);
        p = '{16'h6004, 16'h1001, 16'h8200, 16'hF000, 16'h7007, 16'h1001, 16'h8200,
            16'h1740, 16'h8000};
        run_prog(p, 0, 8, 8'h41, 2'b00, 2'b00);
        p[8] = 16'h8100;
        run_prog(p, 2, 8, 8'h41, 2'b00, 2'b00);
        p = '{16'h1706, 16'h0F02, 16'h1001, 16'h1001, 16'h1001, 16'h1001, 16'h1730,
            16'h8300, 16'h8200};
        run_prog(p, 2, 6, 8'hA5, 2'b00, 2'b00);
        // skip on zero with the byte moved to the accumulator
        p = '{16'h1700, 16'h0F30, 16'h17AA, 16'h5230, 16'h17BB, 16'h1001, 16'h8200};
        run_prog(p, 0, 6, 8'h01, 2'b00, 2'b00);
        $display("flow test done");
    endtask : t_flow
    task automatic t_halt;
        int n;
        logic [7:0] d;
        logic [PC_W-1:0] a;
        miet_prog_t p;
        p = '{16'h1710, 16'h8200, 16'h1001, 16'h8200, 16'h1001, 16'h8200};
        run_prog(p, 0, 1, 8'h10, 2'b00, 2'b00);
        a = prog_addr;
        repeat (20) @(posedge ref_clk);
        #1;
        chk("halted", 16'h0001, {15'h0, halted});
        chk("frozen address", {4'h0, a}, {4'h0, prog_addr});
        reg_read(REG_STATUS, d);
        chk("status halt bit", 16'h0001, {15'h0, d[2]});
        reg_read(4'hF, d);
        chk("unmapped read", 16'h0000, {8'h00, d});
        @(posedge ref_clk);
        wake_req <= 1'b1;
        wait_lvl(1'b0, n);
        @(posedge ref_clk);
        wake_req <= 1'b0;
        wait_lvl(1'b1, n);
        reg_write(REG_CTRL, 8'h03);
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        reg_read(REG_ACC, d);
        chk("acc after wakes", 16'h0012, {8'h00, d});
        reg_read(REG_PC_LO, d);
        chk("pc low", 16'h0006, {8'h00, d});
        reg_read(REG_PC_HI, d);
        chk("pc high", 16'h0000, {8'h00, d});
        // wake with run cleared: core leaves halt but stays idle
        reg_write(REG_CTRL, 8'h02);
        wait_lvl(1'b0, n);
        repeat (12) @(posedge ref_clk);
        reg_read(REG_PC_LO, d);
        chk("pc held idle", 16'h0006, {8'h00, d});
        reg_read(REG_CTRL, d);
        chk("run bit", 16'h0000, {8'h00, d});
        reg_read(REG_ACC, d);
        chk("acc held idle", 16'h0012, {8'h00, d});
        $display("halt test done");
    endtask : t_halt
    initial begin
        t_arith();
        t_mem();
        t_flow();
        t_halt();
        give_verdict();
    end
endmodule : mcu_instruction_execution_timing_tb_top

// ==== dv/miet_core_sva.sv ====
// port assertions for the instruction execution core
`timescale 1ns/1ps
module miet_core_sva
    import miet_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic [miet_pkg::PC_W-1:0] prog_addr, // fetch address
    input wire logic [15:0] prog_data, // fetched word
    input wire logic wake_req, // wake level
    input wire logic [3:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic halted // power-down flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    addr_hold_a: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3])
        else $error("fetch address moved inside an instruction cycle");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    unmapped_rd_a: assert property (reg_rd && reg_addr > REG_PC_HI |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    status_rd_a: assert property (reg_rd && reg_addr == REG_STATUS
        |=> reg_rdata[7:2] == {5'h00, $past(halted)})
        else $error("status read does not show halt state");
    halt_freeze_a: assert property (halted && $past(halted) |-> $stable(prog_addr))
        else $error("fetch address moved while halted");
    halt_stay_a: assert property ((halted && !wake_req && !reg_wr) [*8] |=> halted)
        else $error("left halt without a wake request");
    halt_entry_a: assert property ($rose(halted) |=> (halted && $stable(prog_addr)) [*3])
        else $error("halt not held after entry");
    wake_pin_a: assert property (halted && wake_req |-> ##[1:5] !halted)
        else $error("wake pin did not end halt");
    wake_reg_a: assert property (halted && reg_wr && reg_addr == REG_CTRL
        && reg_wdata[CTRL_WAKE_BIT] |-> ##[1:5] !halted)
        else $error("wake write did not end halt");
endmodule : miet_core_sva
bind miet_core miet_core_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_data(prog_data), .wake_req(wake_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halted(halted));

// ==== dv/miet_prog_mem.sv ====
// program memory model with adjustable answer delay
`timescale 1ns/1ps
module miet_prog_mem
    import miet_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic [miet_pkg::PC_W-1:0] prog_addr, // fetch address
    output logic [15:0] prog_data // fetched word
);
    logic [15:0] rom [0:4095];
    logic [PC_W-1:0] last_addr = 12'h000;
    int cnt = 0;
    int slow = 0;
    // inverted word until the access time has run out
    assign prog_data = (prog_addr == last_addr && cnt >= slow) ? rom[prog_addr] : ~rom[prog_addr];
    always @(posedge ref_clk) begin
        if (prog_addr != last_addr) begin
            last_addr <= prog_addr;
            cnt <= 0;
        end else if (cnt < 7) begin
            cnt <= cnt + 1;
        end
    end
endmodule : miet_prog_mem

// ==== rtl/miet_core.sv ====
// 8-bit core: fetch, decode, execute and instruction timing
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module miet_core
    import miet_pkg::*;
(
    input wire logic ref_clk, // system clock, 10 MHz
    input wire logic rst_n, // asynchronous reset, active low
    output logic [miet_pkg::PC_W-1:0] prog_addr, // program memory address
    input wire logic [15:0] prog_data, // program memory word
    input wire logic wake_req, // wake-up request level
    input wire logic [3:0] reg_addr, // register port address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    output logic halted // core in power-down state
);
    import miet_pkg::*;

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [1:0] phase_ff;
    logic cyc_end;
    miet_state_t state_ff;
    miet_state_t nxt_state;
    logic [PC_W-1:0] pc_ff;
    logic [PC_W-1:0] nxt_pc;
    logic [PC_W-1:0] prog_addr_ff;
    logic [7:0] acc_ff;
    logic [7:0] nxt_acc;
    miet_flags_t flags_ff;
    miet_flags_t nxt_flags;
    logic [7:0] dmem [DM_DEPTH];
    logic [PC_W-1:0] stk [STK_DEPTH];
    logic [2:0] sp_ff;
    logic push;
    logic pop;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_val;
    logic [8:0] res;
    logic [2:0] bidx;
    logic skip;
    logic run_ff;
    logic wake_pend_ff;
    logic wake;
    logic [7:0] reg_rdata_ff;
    miet_instr_t ins;

    // binary operation, bit 8 is carry out or borrow
    function automatic logic [8:0] alu(
        input miet_alu_t op,
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin
    );
        logic [8:0] r;
        r = 9'h000;
        case (op)
            ALU_ADD: r = {1'b0, a} + {1'b0, b};
            ALU_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            ALU_SUB: r = {1'b0, a} - {1'b0, b};
            ALU_SBC: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            ALU_AND: r = {1'b0, a & b};
            ALU_OR: r = {1'b0, a | b};
            ALU_XOR: r = {1'b0, a ^ b};
            ALU_MOV: r = {1'b0, b};
            default: r = 9'h000;
        endcase
        return r;
    endfunction : alu

    // one-operand operation, bit 8 is the new carry
    function automatic logic [8:0] unary(
        input miet_un_t op,
        input logic [7:0] b,
        input logic cin
    );
        logic [8:0] r;
        r = {cin, b};
        case (op)
            UN_COMPLEMENT: r = {cin, ~b};
            UN_INC: r = {cin, b + 8'h01};
            UN_DEC: r = {cin, b - 8'h01};
            UN_ROT_RIGHT: r = {cin, b[0], b[7:1]};
            UN_ROT_LEFT: r = {cin, b[6:0], b[7]};
            UN_ROT_RIGHT_C: r = {b[0], cin, b[7:1]};
            UN_ROT_LEFT_C: r = {b[7], b[6:0], cin};
            default: r = {cin, b};
        endcase
        return r;
    endfunction : unary

    // reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // instruction cycle phase counter
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    assign cyc_end = (phase_ff == PH_LAST);
    assign ins = miet_instr_t'(prog_data);
    assign bidx = ins.sub[2:0];
    assign rd_val = (ins.oper == PC_LO_ADDR) ? pc_ff[7:0] : dmem[ins.oper];
    assign wake = wake_req | wake_pend_ff;

    // execute at the last phase of each instruction cycle
    always_comb begin
        nxt_pc = pc_ff;
        nxt_state = state_ff;
        nxt_acc = acc_ff;
        nxt_flags = flags_ff;
        wr_en = 1'b0;
        wr_data = 8'h00;
        push = 1'b0;
        pop = 1'b0;
        res = 9'h000;
        skip = 1'b0;
        if (cyc_end) begin
            case (state_ff)
                ST_EXEC: begin
                    if (run_ff) begin
                        nxt_pc = pc_ff + 12'h001;
                        case (ins.opc)
                            OPC_ALU_M, OPC_ALU_X: begin
                                res = alu(miet_alu_t'(ins.sub[2:0]), acc_ff,
                                    (ins.opc == OPC_ALU_X) ? ins.oper : rd_val, flags_ff.c);
                                if (miet_alu_t'(ins.sub[2:0]) == ALU_MOV) begin
                                    if (ins.sub[3] && ins.opc == OPC_ALU_M) begin
                                        wr_en = 1'b1;
                                        wr_data = acc_ff;
                                    end else begin
                                        nxt_acc = res[7:0];
                                    end
                                end else begin
                                    nxt_flags.z = (res[7:0] == 8'h00);
                                    if (ins.sub[2] == 1'b0) begin
                                        nxt_flags.c = res[8];
                                    end
                                    if (ins.sub[3] && ins.opc == OPC_ALU_M) begin
                                        wr_en = 1'b1;
                                        wr_data = res[7:0];
                                    end else begin
                                        nxt_acc = res[7:0];
                                    end
                                end
                            end
                            OPC_UNARY: begin
                                res = unary(miet_un_t'(ins.sub[2:0]), rd_val, flags_ff.c);
                                nxt_flags.c = res[8];
                                if (ins.sub[2:0] <= 3'(UN_DEC)) begin
                                    nxt_flags.z = (res[7:0] == 8'h00);
                                end
                                if (ins.sub[3]) begin
                                    wr_en = 1'b1;
                                    wr_data = res[7:0];
                                end else begin
                                    nxt_acc = res[7:0];
                                end
                            end
                            OPC_BIT: begin
                                wr_en = 1'b1;
                                wr_data = rd_val;
                                wr_data[bidx] = ins.sub[3];
                            end
                            OPC_SKIP_BIT: begin
                                skip = (rd_val[bidx] == ins.sub[3]);
                            end
                            OPC_SKIP_BYTE: begin
                                case (ins.sub)
                                    SKB_SZ: skip = (rd_val == 8'h00);
                                    SKB_SNZ: skip = (rd_val != 8'h00);
                                    SKB_SZA: begin
                                        nxt_acc = rd_val;
                                        skip = (rd_val == 8'h00);
                                    end
                                    default: skip = 1'b0;
                                endcase
                            end
                            OPC_JUMP: begin
                                nxt_pc = {ins.sub, ins.oper};
                                nxt_state = ST_DUMMY;
                            end
                            OPC_CALL: begin
                                push = 1'b1;
                                nxt_pc = {ins.sub, ins.oper};
                                nxt_state = ST_DUMMY;
                            end
                            OPC_MISC: begin
                                case (ins.sub)
                                    MISC_SUB_RETURN, MISC_INT_RETURN: begin
                                        pop = 1'b1;
                                        nxt_pc = stk[sp_ff - 3'h1];
                                        nxt_state = ST_DUMMY;
                                    end
                                    MISC_HALT: nxt_state = ST_HALT;
                                    MISC_TABRD: nxt_state = ST_TABLE;
                                    default: nxt_state = ST_EXEC;
                                endcase
                            end
                            default: nxt_state = ST_EXEC;
                        endcase
                        if (skip) begin
                            nxt_pc = pc_ff + 12'h002;
                            nxt_state = ST_DUMMY;
                        end
                        if (wr_en && ins.oper == PC_LO_ADDR) begin
                            nxt_pc = {pc_ff[PC_W-1:8], wr_data};
                            nxt_state = ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: nxt_state = ST_EXEC;
                ST_TABLE: begin
                    nxt_acc = prog_data[7:0];
                    nxt_state = ST_EXEC;
                end
                ST_HALT: begin
                    if (wake) begin
                        nxt_state = ST_EXEC;
                    end
                end
                default: nxt_state = ST_EXEC;
            endcase
        end
    end

    // sequencing state and program counter
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= ST_EXEC;
            pc_ff <= RST_PC;
            prog_addr_ff <= RST_PC;
        end else begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            if (cyc_end) begin
                prog_addr_ff <= (nxt_state == ST_TABLE) ? {TBL_PAGE, acc_ff} : nxt_pc;
            end
        end
    end

    // accumulator and flags
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            acc_ff <= RST_ACC;
            flags_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
            flags_ff <= nxt_flags;
        end
    end

    // data memory, the program counter alias is never stored
    always_ff @(posedge ref_clk) begin
        if (wr_en && ins.oper != PC_LO_ADDR) begin
            dmem[ins.oper] <= wr_data;
        end
    end

    // return address stack
    always_ff @(posedge ref_clk) begin
        if (push) begin
            stk[sp_ff] <= pc_ff + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            sp_ff <= RST_SP;
        end else if (push) begin
            sp_ff <= sp_ff + 3'h1;
        end else if (pop) begin
            sp_ff <= sp_ff - 3'h1;
        end
    end

    // run control and software wake-up, a new wake request wins over the clear
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            run_ff <= RST_RUN;
            wake_pend_ff <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL) begin
                run_ff <= reg_wdata[CTRL_RUN_BIT];
            end
            if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_WAKE_BIT]) begin
                wake_pend_ff <= 1'b1;
            end else if (cyc_end && state_ff == ST_HALT) begin
                wake_pend_ff <= 1'b0;
            end
        end
    end

    // register read data, valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: reg_rdata_ff <= {7'h00, run_ff};
                REG_STATUS: reg_rdata_ff <= {5'h00, state_ff == ST_HALT, flags_ff.c, flags_ff.z};
                REG_ACC: reg_rdata_ff <= acc_ff;
                REG_PC_LO: reg_rdata_ff <= pc_ff[7:0];
                REG_PC_HI: reg_rdata_ff <= {4'h0, pc_ff[PC_W-1:8]};
                default: reg_rdata_ff <= 8'h00;
            endcase
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end

    assign prog_addr = prog_addr_ff;
    assign reg_rdata = reg_rdata_ff;
    assign halted = (state_ff == ST_HALT);

endmodule : miet_core

// ==== rtl/miet_pkg.sv ====
// shared constants and types of the instruction execution core
package miet_pkg;

    // instruction cycle length in system clocks
    localparam int PHASES = 4;
    localparam logic [1:0] PH_LAST = 2'(PHASES - 1);

    localparam int PC_W = 12;
    localparam int DM_DEPTH = 256;
    localparam int STK_DEPTH = 8;
    localparam logic [PC_W-1:0] RST_PC = 12'h000;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [2:0] RST_SP = 3'h0;

    // data address that aliases the low byte of the program counter
    localparam logic [7:0] PC_LO_ADDR = 8'h02;
    // upper program address bits used by table reads
    localparam logic [3:0] TBL_PAGE = 4'hF;

    // register port offsets and fields
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_ACC = 4'h2;
    localparam logic [3:0] REG_PC_LO = 4'h3;
    localparam logic [3:0] REG_PC_HI = 4'h4;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_WAKE_BIT = 1;
    localparam logic RST_RUN = 1'b1;

    typedef enum logic [3:0] {
        OPC_ALU_M = 4'h0,
        OPC_ALU_X = 4'h1,
        OPC_UNARY = 4'h2,
        OPC_BIT = 4'h3,
        OPC_SKIP_BIT = 4'h4,
        OPC_SKIP_BYTE = 4'h5,
        OPC_JUMP = 4'h6,
        OPC_CALL = 4'h7,
        OPC_MISC = 4'h8
    } miet_opc_t;

    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_ADC = 3'h1,
        ALU_SUB = 3'h2,
        ALU_SBC = 3'h3,
        ALU_AND = 3'h4,
        ALU_OR = 3'h5,
        ALU_XOR = 3'h6,
        ALU_MOV = 3'h7
    } miet_alu_t;

    typedef enum logic [2:0] {
        UN_COMPLEMENT = 3'h0,
        UN_INC = 3'h1,
        UN_DEC = 3'h2,
        UN_ROT_RIGHT = 3'h3,
        UN_ROT_LEFT = 3'h4,
        UN_ROT_RIGHT_C = 3'h5,
        UN_ROT_LEFT_C = 3'h6
    } miet_un_t;

    localparam logic [3:0] MISC_SUB_RETURN = 4'h0;
    localparam logic [3:0] MISC_INT_RETURN = 4'h1;
    localparam logic [3:0] MISC_HALT = 4'h2;
    localparam logic [3:0] MISC_TABRD = 4'h3;
    localparam logic [3:0] SKB_SZ = 4'h0;
    localparam logic [3:0] SKB_SNZ = 4'h1;
    localparam logic [3:0] SKB_SZA = 4'h2;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_DUMMY = 2'b01,
        ST_TABLE = 2'b10,
        ST_HALT = 2'b11
    } miet_state_t;

    typedef struct packed {
        miet_opc_t opc;
        logic [3:0] sub;
        logic [7:0] oper;
    } miet_instr_t;

    typedef struct packed {
        logic c;
        logic z;
    } miet_flags_t;

endpackage : miet_pkg
